// ---- logic/upc_ctrl.sv ----
`timescale 1ns/1ps
module upc_ctrl
  import upc_pkg::*;
(
  input  wire logic                        mclk_in,
  input  wire logic                        resetn_in,
  input  wire logic                        ce_in,
  input  wire logic [3:0]                  interface_mode_select_in,
  input  wire logic [3:0]                  stream_count_in,
  input  wire logic [8:0]                  interp_in,
  input  wire logic                        datapath_enable_in,
  input  wire logic                        link_enable_in,
  input  wire logic                        oscillator_mix_enable_in,
  input  wire logic                        direct_synthesis_enable_in,
  input  wire logic [SAMPLE_W-1:0]         constant_in_phase_value_in,
  input  wire logic [SAMPLE_W-1:0]         constant_quadrature_value_in,
  input  wire logic [NUM_UPC*SAMPLE_W-1:0] amplitude_in,
  input  wire logic [NUM_UPC*PHASE_W-1:0]  freq_in,
  input  wire logic [NUM_UPC*2-1:0]        gain_shift_in,
  input  wire logic [NUM_UPC-1:0]          route_ch0_in,
  input  wire logic [NUM_UPC-1:0]          route_ch1_in,
  input  wire logic [NUM_UPC*SAMPLE_W-1:0] link_i_in,
  input  wire logic [NUM_UPC*SAMPLE_W-1:0] link_q_in,
  output logic [SAMPLE_W-1:0]              converter_channel_0_out,
  output logic [SAMPLE_W-1:0]              converter_channel_1_out,
  output logic [NUM_UPC-1:0]               upc_active_out,
  output logic [1:0]                       op_out,
  output logic                             config_error_out
);
  upc_op_t                     op;
  upc_op_t                     next_op;
  logic [NUM_UPC-1:0]          next_active;
  logic                        cfg_ok;
  logic [8:0]                  min_interp;
  logic signed [SAMPLE_W-1:0]  lane_out [NUM_UPC];
  logic signed [SAMPLE_W+1:0]  sum0;
  logic signed [SAMPLE_W+1:0]  sum1;

  assign min_interp = upc_min_interp(stream_count_in);
  assign cfg_ok = (min_interp != 9'h000) && (interp_in >= min_interp) && (interp_in <= INTERP_MAX);

  always_comb begin
    next_op = UPC_IDLE;
    if (datapath_enable_in) begin
      if (interface_mode_select_in == MODE_BYPASS) begin
        next_op = link_enable_in ? UPC_BYPASS : UPC_IDLE;
      end else if (interface_mode_select_in <= MODE_MIX_MAX && cfg_ok) begin
        if (!link_enable_in) begin
          next_op = UPC_CONST;
        end else if (oscillator_mix_enable_in || direct_synthesis_enable_in) begin
          next_op = UPC_MIX;
        end
      end
    end
  end

  always_comb begin
    unique case (stream_count_in)
      4'h2: next_active = 4'b0001;
      4'h4: next_active = 4'b0011;
      4'h6: next_active = 4'b0111;
      4'h8: next_active = 4'b1111;
      default: next_active = 4'b0000;
    endcase
    if (next_op == UPC_IDLE || next_op == UPC_BYPASS) begin
      next_active = '0;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op             <= UPC_IDLE;
      upc_active_out <= '0;
    end else if (ce_in) begin
      op             <= next_op;
      upc_active_out <= next_active;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_out           <= 2'h0;
      config_error_out <= 1'b0;
    end else if (ce_in) begin
      op_out           <= 2'(next_op);
      config_error_out <= datapath_enable_in && interface_mode_select_in != MODE_BYPASS && !cfg_ok;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_UPC; g++) begin : g_lane
      upc_lane u_lane (
        .mclk_in      (mclk_in),
        .resetn_in    (resetn_in),
        .ce_in        (ce_in),
        .run_in       (upc_active_out[g]),
        .use_const_in (op == UPC_CONST),
        .dds_in       (direct_synthesis_enable_in),
        .link_i_in    (link_i_in[g*SAMPLE_W +: SAMPLE_W]),
        .link_q_in    (link_q_in[g*SAMPLE_W +: SAMPLE_W]),
        .const_i_in   (constant_in_phase_value_in),
        .const_q_in   (constant_quadrature_value_in),
        .amplitude_in (amplitude_in[g*SAMPLE_W +: SAMPLE_W]),
        .freq_in      (freq_in[g*PHASE_W +: PHASE_W]),
        .gain_shift_in(gain_shift_in[g*2 +: 2]),
        .sample_out   (lane_out[g])
      );
    end
  endgenerate

  // wide sums with saturation, in case attenuation was not programmed
  always_comb begin
    sum0 = '0;
    sum1 = '0;
    for (int k = 0; k < NUM_UPC; k++) begin
      if (route_ch0_in[k]) sum0 = sum0 + (SAMPLE_W+2)'(lane_out[k]);
      if (route_ch1_in[k]) sum1 = sum1 + (SAMPLE_W+2)'(lane_out[k]);
    end
  end

  function automatic logic [SAMPLE_W-1:0] sat_ob(input logic signed [SAMPLE_W+1:0] v);
    if (v > (SAMPLE_W+2)'(signed'({2'b00, FULL_SCALE}))) sat_ob = 16'hffff;
    else if (v < -(SAMPLE_W+2)'(signed'({2'b00, FULL_SCALE}))) sat_ob = 16'h0001;
    else sat_ob = v[SAMPLE_W-1:0] ^ OFFSET_ZERO;
  endfunction : sat_ob

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      converter_channel_0_out <= OFFSET_ZERO;
      converter_channel_1_out <= OFFSET_ZERO;
    end else if (ce_in) begin
      unique case (op)
        UPC_BYPASS: begin
          converter_channel_0_out <= link_i_in[SAMPLE_W-1:0];
          converter_channel_1_out <= link_q_in[SAMPLE_W-1:0];
        end
        UPC_MIX, UPC_CONST: begin
          converter_channel_0_out <= sat_ob(sum0);
          converter_channel_1_out <= sat_ob(sum1);
        end
        default: begin
          converter_channel_0_out <= OFFSET_ZERO;
          converter_channel_1_out <= OFFSET_ZERO;
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  sequence const_cond_s;
    ce_in && datapath_enable_in && !link_enable_in && interface_mode_select_in != MODE_BYPASS
      && interface_mode_select_in <= MODE_MIX_MAX && cfg_ok;
  endsequence

  const_entry_a: assert property (const_cond_s |=> op == UPC_CONST) else $error("const mode not entered");
  bypass_path_a: assert property (ce_in && op == UPC_BYPASS |=> converter_channel_0_out == $past(link_i_in[15:0]))
    else $error("bypass sample mismatch");
  mode_zero_a: assert property (ce_in && interface_mode_select_in == MODE_BYPASS |=> upc_active_out == '0)
    else $error("upconverter active in mode zero");
  mix_range_a: assert property (ce_in && interface_mode_select_in > MODE_MIX_MAX |=> op == UPC_IDLE)
    else $error("mixing outside modes 1 to 7");
  interp_min_a: assert property (ce_in && datapath_enable_in && interp_in < 9'h002 |=> upc_active_out == '0)
    else $error("upconverter active below 2x");
  count_map_a: assert property (ce_in && (next_op == UPC_MIX || next_op == UPC_CONST) && stream_count_in == 4'h6
    |=> upc_active_out == 4'b0111)
    else $error("wrong upconverter count");
  max_interp_a: assert property (ce_in && interp_in > INTERP_MAX |=> upc_active_out == '0)
    else $error("active above 256x");
  dp_off_a: assert property (ce_in && !datapath_enable_in |=> ##1 (converter_channel_0_out == OFFSET_ZERO)[*1])
    else $error("output not idle with datapath off");
endmodule : upc_ctrl

// ---- logic/upc_pkg.sv ----
package upc_pkg;
  localparam int unsigned NUM_UPC      = 4;
  localparam int unsigned SAMPLE_W     = 16;
  localparam int unsigned PHASE_W      = 16;
  localparam logic [3:0]  MODE_BYPASS  = 4'h0;
  localparam logic [3:0]  MODE_MIX_MAX = 4'h7;
  localparam logic [8:0]  INTERP_MAX   = 9'h100;
  localparam logic [15:0] FULL_SCALE   = 16'h7fff;
  localparam logic [15:0] OFFSET_ZERO  = 16'h8000;
  localparam logic [1:0]  RST_ROUTE    = 2'h0;

  typedef enum logic [1:0] {
    UPC_IDLE,
    UPC_BYPASS,
    UPC_MIX,
    UPC_CONST
  } upc_op_t;

  // least interpolation for a stream count; zero marks an unsupported count
  function automatic logic [8:0] upc_min_interp(input logic [3:0] streams);
    case (streams)
      4'h2:    upc_min_interp = 9'h002;
      4'h4:    upc_min_interp = 9'h004;
      4'h6:    upc_min_interp = 9'h008;
      4'h8:    upc_min_interp = 9'h008;
      default: upc_min_interp = 9'h000;
    endcase
  endfunction : upc_min_interp
endpackage : upc_pkg

// ---- logic/upc_lane.sv ----
`timescale 1ns/1ps
// one upconverter: sample source select, oscillator, two's-complement mixing
module upc_lane
  import upc_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                resetn_in,
  input  wire logic                ce_in,
  input  wire logic                run_in,
  input  wire logic                use_const_in,
  input  wire logic                dds_in,
  input  wire logic [SAMPLE_W-1:0] link_i_in,
  input  wire logic [SAMPLE_W-1:0] link_q_in,
  input  wire logic [SAMPLE_W-1:0] const_i_in,
  input  wire logic [SAMPLE_W-1:0] const_q_in,
  input  wire logic [SAMPLE_W-1:0] amplitude_in,
  input  wire logic [PHASE_W-1:0]  freq_in,
  input  wire logic [1:0]          gain_shift_in,
  output logic signed [SAMPLE_W-1:0] sample_out
);
  logic        [PHASE_W-1:0]  phase;
  logic signed [SAMPLE_W-1:0] src_i;
  logic signed [SAMPLE_W-1:0] src_q;
  logic signed [SAMPLE_W-1:0] next_out;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase <= '0;
    end else if (ce_in) begin
      phase <= run_in ? phase + freq_in : '0;
    end
  end

  // quarter-wave carrier keeps the lane small; a lookup table would refine it
  always_comb begin
    // link words are offset binary: flip msb to two's complement
    src_i = use_const_in ? signed'(const_i_in) : signed'(link_i_in ^ OFFSET_ZERO);
    src_q = use_const_in ? signed'(const_q_in) : signed'(link_q_in ^ OFFSET_ZERO);
    if (dds_in) begin
      src_i = signed'(amplitude_in);
      src_q = '0;
    end
    unique case (phase[PHASE_W-1 -: 2])
      2'h0: next_out = src_i;
      2'h1: next_out = -src_q;
      2'h2: next_out = -src_i;
      default: next_out = src_q;
    endcase
    next_out = next_out >>> gain_shift_in;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sample_out <= '0;
    end else if (ce_in) begin
      sample_out <= run_in ? next_out : '0;
    end
  end
endmodule : upc_lane

// ---- verification/upc_link_src.sv ----
`timescale 1ns/1ps
module upc_link_src
  import upc_pkg::*;
(
  input  wire logic                        mclk_in,
  input  wire logic                        resetn_in,
  input  wire logic                        hold_in,
  output logic [NUM_UPC*SAMPLE_W-1:0]      link_i_out,
  output logic [NUM_UPC*SAMPLE_W-1:0]      link_q_out
);
  logic [SAMPLE_W-1:0] count;
  // words move every cycle unless held, so a stale word is never mistaken for fresh data
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= 16'h1234;
    end else if (!hold_in) begin
      count <= count + 16'h0101;
    end
  end
  // offset binary: midscale stands for zero
  always_comb begin
    for (int g = 0; g < NUM_UPC; g++) begin
      link_i_out[g*SAMPLE_W+:SAMPLE_W] = count ^ 16'h8000 ^ SAMPLE_W'(g);
      link_q_out[g*SAMPLE_W+:SAMPLE_W] = ~count;
    end
  end
endmodule : upc_link_src

// ---- verification/upconverter_nco_source_control_tb.sv ----
`timescale 1ns/1ps
module upconverter_nco_source_control_tb;
  import upc_pkg::*;
  logic        mclk_in   = 1'b0;
  logic        resetn_in = 1'b0;
  logic        dp = 1'b0, link = 1'b0, osc = 1'b0, dds = 1'b0, hold = 1'b1;
  logic [3:0]  mode = 4'h0, streams = 4'h2, r0 = 4'h1, r1 = 4'h1, act;
  logic [8:0]  interp = 9'h002;
  logic [7:0]  gain = 8'h00;
  logic [63:0] li, lq;
  logic [15:0] ch0, ch1;
  logic [1:0]  op;
  logic        err;
  int          errors = 0, samples_checked = 0;
  logic [8:0]  mins [4] = '{9'h002, 9'h004, 9'h008, 9'h008};

  always #4 mclk_in = ~mclk_in;

  upc_link_src u_src (.mclk_in(mclk_in), .resetn_in(resetn_in), .hold_in(hold),
    .link_i_out(li), .link_q_out(lq));

  upc_ctrl u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(1'b1),
    .interface_mode_select_in(mode), .stream_count_in(streams), .interp_in(interp),
    .datapath_enable_in(dp), .link_enable_in(link), .oscillator_mix_enable_in(osc),
    .direct_synthesis_enable_in(dds), .constant_in_phase_value_in(FULL_SCALE),
    .constant_quadrature_value_in(16'h0000), .amplitude_in({4{16'h4000}}), .freq_in(64'h0),
    .gain_shift_in(gain), .route_ch0_in(r0), .route_ch1_in(r1), .link_i_in(li), .link_q_in(lq),
    .converter_channel_0_out(ch0), .converter_channel_1_out(ch1), .upc_active_out(act),
    .op_out(op), .config_error_out(err));

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : step

  // settings change only with the datapath and then the link switched off
  task automatic cfg(input logic [3:0] m, s, input logic [8:0] f, input logic l, o, d,
                     input logic [3:0] a, b, input logic [7:0] g);
    dp <= 1'b0;
    step(1);
    link <= 1'b0;
    step(1);
    mode <= m;
    streams <= s;
    interp <= f;
    osc <= o;
    dds <= d;
    r0 <= a;
    r1 <= b;
    gain <= g;
    step(1);
    link <= l;
    step(1);
    dp <= 1'b1;
    step(4);
  endtask : cfg

  task automatic chk_st(input logic [1:0] eo, input logic [3:0] ea, input logic ee);
    @(negedge mclk_in);
    samples_checked++;
    if ({op, act, err} !== {eo, ea, ee}) begin
      errors++;
      $display("Error %0t status op %h lanes %h err %b", $time, op, act, err);
    end
  endtask : chk_st

  task automatic chk_ch(input logic [15:0] e0, e1);
    @(negedge mclk_in);
    samples_checked++;
    if ({ch0, ch1} !== {e0, e1}) begin
      errors++;
      $display("Error %0t channels %h %h expected %h %h", $time, ch0, ch1, e0, e1);
    end
  endtask : chk_ch

  task automatic test_done;
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    step(2);
    chk_st(2'h0, 4'h0, 1'b0);
    chk_ch(OFFSET_ZERO, OFFSET_ZERO);
    @(posedge mclk_in);
    resetn_in <= 1'b1;
    cfg(MODE_BYPASS, 4'h2, 9'h002, 1'b1, 1'b0, 1'b0, 4'h1, 4'h1, 8'h00);
    chk_st(2'h1, 4'h0, 1'b0);
    chk_ch(li[15:0], lq[15:0]);
    cfg(4'h1, 4'h2, 9'h002, 1'b1, 1'b1, 1'b0, 4'h1, 4'h1, 8'h00);
    chk_st(2'h2, 4'h1, 1'b0);
    cfg(MODE_MIX_MAX, 4'h2, 9'h001, 1'b1, 1'b1, 1'b0, 4'h1, 4'h1, 8'h00);
    chk_st(2'h0, 4'h0, 1'b1);
    chk_ch(OFFSET_ZERO, OFFSET_ZERO);
    for (int k = 0; k < 4; k++) begin
      cfg(4'h3, 4'(2*k+2), mins[k], 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 8'h00);
      chk_st(2'h3, 4'((1 << (k+1)) - 1), 1'b0);
      cfg(4'h3, 4'(2*k+2), mins[k] - 9'h001, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 8'h00);
      chk_st(2'h0, 4'h0, 1'b1);
    end
    cfg(4'h3, 4'h8, INTERP_MAX, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 8'h00);
    chk_st(2'h3, 4'hf, 1'b0);
    cfg(4'h3, 4'h8, INTERP_MAX + 9'h001, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 8'h00);
    chk_st(2'h0, 4'h0, 1'b1);
    hold <= 1'b0;
    cfg(4'h3, 4'h2, 9'h002, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 8'h00);
    chk_ch(16'hffff, 16'hffff);
    step(3);
    chk_ch(16'hffff, 16'hffff);
    cfg(4'h3, 4'h8, 9'h008, 1'b0, 1'b0, 1'b0, 4'h3, 4'hc, 8'h55);
    chk_ch(16'hfffe, 16'hfffe);
    cfg(4'h3, 4'h2, 9'h002, 1'b0, 1'b0, 1'b1, 4'h1, 4'h1, 8'h00);
    chk_ch(16'hc000, 16'hc000);
    test_done;
  end

  // the sequence needs about 150 cycles; this bound only catches a hang
  initial begin
    step(5000);
    errors++;
    test_done;
  end
endmodule : upconverter_nco_source_control_tb
